// ===== rtl/adcm_top.sv
// Mode, start and result registers of the 10-bit converter
//
// Notes on behaviour
// - Mode register at 0xc6 holds clock select in bit 7, trigger enable in bit 6, channel in bits 3 to 0.
// - Channel upper bits 00 select nothing, 01 inputs 0-3, 10 inputs 4-7, lower bits pick within the group.
// - With trigger enable clear the trigger pin is ignored and only software starts a conversion.
// - With trigger enable set either edge on the trigger pin starts a conversion.
// - Mode register resets to zero in its writable bits and bits 5 and 4 read as one.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module adcm_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Register port
  input wire adcm_pkg::adcm_bus_req_type BUS_I,
  output logic [7:0] RD_DATA_O,
  // External trigger pin
  input wire logic EXT_TRIGGER_PIN_I,
  // Analog front end
  input wire logic COMP_I,
  output logic [9:0] DAC_O,
  output logic CHAN_EN_O,
  output logic [2:0] CHAN_SEL_O,
  // Interrupt
  output logic IRQ_O
);

  typedef struct packed {
    adcm_pkg::adcm_mode_type mode;
    adcm_pkg::adcm_chan_type chan;
    logic run;
    logic [9:0] result;
    logic trig_prev;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
  } adcm_top_st_type;

  adcm_top_st_type st_r;
  adcm_top_st_type st_nxt;

  // Sequencer handshake
  logic start_req;
  logic abort_req;
  logic sar_busy;
  logic sar_done;
  logic [9:0] sar_result;

  // Register decode
  logic wr_mode;
  logic wr_start;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic sw_start;
  logic sw_stop;
  logic trig_edge;

  function automatic logic hit(input adcm_pkg::adcm_bus_req_type req,
                               input logic [7:0] off);
    return req.addr == off;
  endfunction

  always_comb begin
    wr_mode = BUS_I.wr && hit(BUS_I, adcm_pkg::OFF_MODE);
    wr_start = BUS_I.wr && hit(BUS_I, adcm_pkg::OFF_START_STATUS);
    wr_irq_status = BUS_I.wr && hit(BUS_I, adcm_pkg::OFF_IRQ_STATUS);
    wr_irq_mask = BUS_I.wr && hit(BUS_I, adcm_pkg::OFF_IRQ_MASK);
  end

  // Start and stop from software
  always_comb begin
    sw_start = wr_start && BUS_I.wdata[adcm_pkg::START_RUN_BIT];
    sw_stop = wr_start && !BUS_I.wdata[adcm_pkg::START_RUN_BIT];
  end

  // Pin is synchronous, so one earlier sample is enough for edges
  always_comb begin
    trig_edge = 1'b0;
    if (st_r.mode.ext_trigger_enable) begin
      trig_edge = EXT_TRIGGER_PIN_I != st_r.trig_prev;
    end
  end

  // A start while busy is dropped; a stop beats a same-cycle trigger
  always_comb begin
    start_req = 1'b0;
    abort_req = 1'b0;
    if (sw_stop) begin
      abort_req = st_r.run;
    end else if (!st_r.run && !sar_busy && (sw_start || trig_edge)) begin
      start_req = 1'b1;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.trig_prev = EXT_TRIGGER_PIN_I;

    // Mode register
    if (wr_mode) begin
      st_nxt.mode.conv_clock_select =
        BUS_I.wdata[adcm_pkg::MODE_CLK_SEL_BIT];
      st_nxt.mode.ext_trigger_enable =
        BUS_I.wdata[adcm_pkg::MODE_TRIG_EN_BIT];
      st_nxt.mode.channel_select =
        BUS_I.wdata[adcm_pkg::MODE_CH_LSB +: adcm_pkg::MODE_CH_W];
    end
    // Forbidden channel codes decode to no channel
    st_nxt.chan = adcm_pkg::adcm_decode_chan(
      st_nxt.mode.channel_select);

    // Run flag and result
    if (start_req) begin
      st_nxt.run = 1'b1;
    end else if (abort_req) begin
      st_nxt.run = 1'b0;
    end else if (sar_done) begin
      st_nxt.run = 1'b0;
      st_nxt.result = sar_result;
    end

    // Interrupt flags; a new event wins over a same-cycle clear
    if (wr_irq_status) begin
      st_nxt.irq_status = st_r.irq_status & ~BUS_I.wdata[1:0];
    end
    if (sar_done && !abort_req) begin
      st_nxt.irq_status[adcm_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (trig_edge && start_req) begin
      st_nxt.irq_status[adcm_pkg::IRQ_TRIG_BIT] = 1'b1;
    end
    if (wr_irq_mask) begin
      st_nxt.irq_mask = BUS_I.wdata[1:0];
    end

    // Read data stands for exactly one cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (BUS_I.rd) begin
      case (BUS_I.addr)
        adcm_pkg::OFF_RESULT_HIGH: begin
          st_nxt.rdata = st_r.result[9:2];
        end
        adcm_pkg::OFF_RESULT_LOW: begin
          st_nxt.rdata = {st_r.result[1:0], 6'h00};
        end
        adcm_pkg::OFF_MODE: begin
          st_nxt.rdata = adcm_pkg::MODE_FIXED_ONES
            | {st_r.mode.conv_clock_select,
               st_r.mode.ext_trigger_enable,
               2'h0,
               st_r.mode.channel_select};
        end
        adcm_pkg::OFF_START_STATUS: begin
          st_nxt.rdata = adcm_pkg::START_FIXED_ONES
            | {st_r.run, 7'h00};
        end
        adcm_pkg::OFF_IRQ_STATUS: begin
          st_nxt.rdata = {6'h00, st_r.irq_status};
        end
        adcm_pkg::OFF_IRQ_MASK: begin
          st_nxt.rdata = {6'h00, st_r.irq_mask};
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r.mode <= adcm_pkg::MODE_RESET;
      st_r.chan <= '0;
      st_r.run <= 1'b0;
      st_r.result <= adcm_pkg::RESULT_RESET;
      st_r.trig_prev <= 1'b0;
      st_r.irq_status <= adcm_pkg::IRQ_RESET;
      st_r.irq_mask <= adcm_pkg::IRQ_RESET;
      st_r.rdata <= adcm_pkg::RDATA_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Trial levels and bit decisions run in the sequencer
  adcm_sar u_sar (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .start_i(start_req),
    .abort_i(abort_req),
    .long_i(!st_r.mode.conv_clock_select),
    .comp_i(COMP_I),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .result_o(sar_result),
    .dac_o(DAC_O)
  );

  assign RD_DATA_O = st_r.rdata;
  assign CHAN_EN_O = st_r.chan.en;
  assign CHAN_SEL_O = st_r.chan.idx;
  assign IRQ_O = |(st_r.irq_status & st_r.irq_mask);

endmodule
`default_nettype wire

// ===== rtl/adcm_pkg.sv
// Shared constants and types of the converter control block
package adcm_pkg;

  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;

  // Register byte addresses
  localparam logic [7:0] OFF_RESULT_HIGH = 8'hc4;
  localparam logic [7:0] OFF_RESULT_LOW = 8'hc5;
  localparam logic [7:0] OFF_MODE = 8'hc6;
  localparam logic [7:0] OFF_START_STATUS = 8'hc7;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hce;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hcf;

  // Field positions
  localparam int MODE_CLK_SEL_BIT = 7;
  localparam int MODE_TRIG_EN_BIT = 6;
  localparam int MODE_CH_LSB = 0;
  localparam int MODE_CH_W = 4;
  localparam int START_RUN_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values and bits that always read as one
  localparam logic [7:0] MODE_FIXED_ONES = 8'h30;
  localparam logic [7:0] START_FIXED_ONES = 8'h7f;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Conversion timing in system clock periods
  localparam int CONV_PERIOD_LONG = 62;
  localparam int CONV_PERIOD_SHORT = 31;
  localparam int SAMPLE_LONG = 2;
  localparam int SAMPLE_SHORT = 1;
  localparam int STEP_LONG = (CONV_PERIOD_LONG - SAMPLE_LONG) / RES_W;
  localparam int STEP_SHORT = (CONV_PERIOD_SHORT - SAMPLE_SHORT) / RES_W;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcm_bus_req_type;

  // Mode register contents
  typedef struct packed {
    logic conv_clock_select;
    logic ext_trigger_enable;
    logic [3:0] channel_select;
  } adcm_mode_type;

  // Analog multiplexer steering
  typedef struct packed {
    logic en;
    logic [2:0] idx;
  } adcm_chan_type;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_TRIAL
  } adcm_sar_state_type;

  // Upper bits 00 or 11 select nothing; 01 is inputs 0-3, 10 inputs 4-7
  function automatic adcm_chan_type adcm_decode_chan(input logic [3:0] ch);
    adcm_chan_type c;
    c.en = ch[3] ^ ch[2];
    c.idx = {ch[3], ch[1:0]};
    return c;
  endfunction

endpackage

// ===== rtl/adcm_sar.sv
// Successive-approximation sequencer for one 10-bit conversion
`timescale 1ns/1ns
`default_nettype none
module adcm_sar (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic long_i,
  // Comparator: high while input is at or above the trial level
  input wire logic comp_i,
  // Results
  output logic busy_o,
  output logic done_o,
  output logic [9:0] result_o,
  output logic [9:0] dac_o
);

  typedef struct packed {
    adcm_pkg::adcm_sar_state_type phase;
    logic long_mode;
    logic [2:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] trial;
    logic [9:0] result;
    logic done;
  } adcm_sar_st_type;

  adcm_sar_st_type st_r;
  adcm_sar_st_type st_nxt;

  function automatic logic [2:0] step_last(input logic long_mode);
    return long_mode ? 3'(adcm_pkg::STEP_LONG - 1)
                     : 3'(adcm_pkg::STEP_SHORT - 1);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.phase)
      adcm_pkg::SAR_IDLE: begin
        if (start_i) begin
          st_nxt.phase = adcm_pkg::SAR_SAMPLE;
          st_nxt.long_mode = long_i;
          st_nxt.cnt = long_i ? 3'(adcm_pkg::SAMPLE_LONG - 1)
                              : 3'(adcm_pkg::SAMPLE_SHORT - 1);
          st_nxt.trial = 10'h000;
        end
      end
      adcm_pkg::SAR_SAMPLE: begin
        if (st_r.cnt == 3'h0) begin
          st_nxt.phase = adcm_pkg::SAR_TRIAL;
          st_nxt.bit_idx = 4'h9;
          st_nxt.trial = 10'h200;
          st_nxt.cnt = step_last(st_r.long_mode);
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      adcm_pkg::SAR_TRIAL: begin
        if (st_r.cnt == 3'h0) begin
          // Decide at the end of the step so the comparator has settled
          st_nxt.trial[st_r.bit_idx] = comp_i;
          if (st_r.bit_idx == 4'h0) begin
            st_nxt.result = {st_r.trial[9:1], comp_i};
            st_nxt.done = 1'b1;
            st_nxt.phase = adcm_pkg::SAR_IDLE;
          end else begin
            st_nxt.bit_idx = st_r.bit_idx - 4'h1;
            st_nxt.trial[st_r.bit_idx - 4'h1] = 1'b1;
            st_nxt.cnt = step_last(st_r.long_mode);
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      default: begin
        st_nxt.phase = adcm_pkg::SAR_IDLE;
      end
    endcase
    if (abort_i) begin
      st_nxt.phase = adcm_pkg::SAR_IDLE;
      st_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = (st_r.phase != adcm_pkg::SAR_IDLE);
  assign done_o = st_r.done;
  assign result_o = st_r.result;
  assign dac_o = st_r.trial;

endmodule
`default_nettype wire

// ===== tb/adcm_ana.sv
// Analog source model: comparator against a held input level
`timescale 1ns/1ns
`default_nettype none
module adcm_ana (
  // Trial level and held input
  input wire logic [9:0] dac_i,
  input wire logic [9:0] level_i,
  // Comparator
  output logic comp_o
);
  assign comp_o = level_i >= dac_i;
endmodule
`default_nettype wire

// ===== tb/adcm_chk_sva.sv
// Port checker of the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcm_chk (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Watched ports
  input wire adcm_pkg::adcm_bus_req_type BUS_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic EXT_TRIGGER_PIN_I,
  input wire logic [9:0] DAC_O,
  input wire logic CHAN_EN_O,
  input wire logic [2:0] CHAN_SEL_O
);
  logic [5:0] mode_r;
  logic pin_r;
  logic [6:0] cnt_r;
  logic mw;
  logic mr;
  logic sws;
  logic trs;
  assign mw = BUS_I.wr && BUS_I.addr == 8'hc6;
  assign mr = BUS_I.rd && BUS_I.addr == 8'hc6;
  assign sws = BUS_I.wr && BUS_I.addr == 8'hc7 && BUS_I.wdata[7];
  assign trs = mode_r[4] && EXT_TRIGGER_PIN_I != pin_r;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Busy window outlasts a conversion, so a late finish never looks idle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mode_r <= 6'h00;
      pin_r <= 1'b0;
      cnt_r <= 7'h00;
    end else begin
      pin_r <= EXT_TRIGGER_PIN_I;
      if (mw) begin
        mode_r <= {BUS_I.wdata[7:6], BUS_I.wdata[3:0]};
      end
      if (cnt_r == 7'h00 && (sws || trs)) begin
        cnt_r <= mode_r[5] ? 7'h22 : 7'h41;
      end else if (cnt_r != 7'h00) begin
        cnt_r <= cnt_r - 7'h01;
      end
    end
  end
  a_mode_fields: assert property (mr |=> RD_DATA_O ==
    {mode_r[5:4], 2'b11, mode_r[3:0]}) else $error("mode fields");
  a_chan_decode: assert property (mw ##1 !mw |=>
    CHAN_EN_O == (mode_r[3] ^ mode_r[2]) &&
    (!CHAN_EN_O || CHAN_SEL_O == {mode_r[3], mode_r[1:0]}))
    else $error("channel decode");
  a_trig_ignored: assert property (
    (cnt_r == 7'h00 && !mode_r[4] && !sws) [*4] |=> $stable(DAC_O))
    else $error("start while idle");
  a_trig_start: assert property (cnt_r == 7'h00 && trs && !sws |->
    ##[2:5] DAC_O == 10'h200) else $error("trigger start");
  a_mode_ones: assert property (mr |=> RD_DATA_O[5:4] == 2'b11)
    else $error("mode unused bits");
  a_soft_start: assert property (cnt_r == 7'h00 && sws |->
    ##[2:5] DAC_O == 10'h200) else $error("software start");
endmodule
bind adcm_top adcm_chk u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .BUS_I(BUS_I), .RD_DATA_O(RD_DATA_O),
  .EXT_TRIGGER_PIN_I(EXT_TRIGGER_PIN_I), .DAC_O(DAC_O),
  .CHAN_EN_O(CHAN_EN_O), .CHAN_SEL_O(CHAN_SEL_O));
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  adcm_pkg::adcm_bus_req_type bus = '0;
  logic pin = 1'b0;
  logic [9:0] lvl = 10'h000;
  logic [7:0] rdo;
  logic comp;
  logic [9:0] dac;
  logic cen;
  logic [2:0] csel;
  logic irq;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int res_q[$];
  int model_res = 0;
  always #10 clk = ~clk;
  adcm_top dut (.CLK_I(clk), .RESETN_I(rstn), .BUS_I(bus), .RD_DATA_O(rdo),
    .EXT_TRIGGER_PIN_I(pin), .COMP_I(comp), .DAC_O(dac), .CHAN_EN_O(cen),
    .CHAN_SEL_O(csel), .IRQ_O(irq));
  adcm_ana ana (.dac_i(dac), .level_i(lvl), .comp_o(comp));
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input int e, input logic [9:0] g);
    checked++;
    if (g !== e[9:0]) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: w, rd: 1'b0};
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) go(1'b0, 8'h00, 8'h00);
  endtask
  // Read data stand one cycle only, so take them mid-cycle
  task automatic rd(input logic [7:0] a, input string s, input int e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(s, e, {2'b00, rdo});
    @(posedge clk);
  endtask
  // Model result register: an aborted run leaves the last result
  task automatic res();
    if (res_q.size() > 0) begin
      model_res = res_q.pop_front();
    end
    rd(8'hc4, "res_hi", model_res >> 2);
    rd(8'hc5, "res_lo", (model_res & 3) << 6);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h47c5));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'hc6, "mode", 8'h30);
    rd(8'hc7, "status", 8'h7f);
    rd(8'hc0, "unmapped", 0);
    $display("test reset done");
    // Codes 11xx are never written
    for (int ch = 0; ch < 12; ch++) begin
      int m;
      m = ch | (($urandom & 1) << 7);
      go(1'b1, 8'hc6, m[7:0]);
      rd(8'hc6, "mode", m | 8'h30);
      chk("chan_en", ch >> 2 == 1 || ch >> 2 == 2, {9'h000, cen});
      if (ch > 3) begin
        chk("chan_sel", (ch >> 3) * 4 + (ch & 3), {7'h00, csel});
      end
    end
    $display("test channels done");
    for (int k = 0; k < 2; k++) begin
      lvl <= 10'($urandom);
      go(1'b1, 8'hc6, k ? 8'h85 : 8'h05);
      res_q.push_back(lvl);
      go(1'b1, 8'hc7, 8'h80);
      idle(k ? 31 : 62);
      rd(8'hc7, "run", 8'hff);
      rd(8'hc7, "run", 8'h7f);
      res();
      rd(8'hce, "irq_st", 1);
      chk("irq", k, {9'h000, irq});
      go(1'b1, 8'hcf, 8'h01);
      idle(2);
      chk("irq", 1, {9'h000, irq});
      go(1'b1, 8'hce, 8'h01);
      idle(2);
      chk("irq", 0, {9'h000, irq});
      $display("test conversion %0d done", k);
    end
    lvl <= 10'($urandom);
    go(1'b1, 8'hc7, 8'h80);
    idle(5);
    go(1'b1, 8'hc7, 8'h00);
    idle(1);
    rd(8'hc7, "run", 8'h7f);
    idle(40);
    rd(8'hce, "irq_st", 0);
    res();
    $display("test abort done");
    pin <= ~pin;
    idle(3);
    rd(8'hc7, "run", 8'h7f);
    pin <= ~pin;
    idle(40);
    rd(8'hce, "irq_st", 0);
    $display("test trigger off done");
    lvl <= 10'($urandom);
    go(1'b1, 8'hc6, 8'h45);
    res_q.push_back(lvl);
    pin <= ~pin;
    idle(3);
    rd(8'hc7, "run", 8'hff);
    idle(70);
    rd(8'hce, "irq_st", 8'h03);
    res();
    $display("test trigger on done");
    end_of_test();
  end
endmodule
`default_nettype wire
